// ---- dv/i2c_mst.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_mst (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_oe,
    output logic      sda_oe
);
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // open drain; the wait on scl honours slave stretching
    task automatic bit_x(input logic b, output logic r);
        scl_oe = 1'b1;
        #50 sda_oe = ~b;
        #50 scl_oe = 1'b0;
        wait (scl);
        r = sda;
        #100;
    endtask
    // repeated start keeps the bus instead of a stop
    task automatic start();
        sda_oe = 1'b0;
        #100 scl_oe = 1'b0;
        wait (scl);
        #100 sda_oe = 1'b1;
        #100;
    endtask
    task automatic stop();
        scl_oe = 1'b1;
        #100 sda_oe = 1'b1;
        #100 scl_oe = 1'b0;
        #100 sda_oe = 1'b0;
        #100;
    endtask
    task automatic xfer(input logic [8:0] o, output logic [8:0] i);
        for (int k = 8; k >= 0; k--) bit_x(o[k], i[k]);
        scl_oe = 1'b1;
        #100;
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import tw_pkg::*;
    logic ref_clk = 0, reset = 1, arb = 0, pend = 0;
    av_req_s req = '0;
    logic [31:0] rdata, exp_q[$];
    logic wait_r, scl_e, sda_e, m_scl, m_sda;
    logic [7:0] v, d;
    logic [8:0] r;
    int mismatches = 0, cmp_count = 0;
    wire scl = ~(scl_e | m_scl);
    wire sda = ~(sda_e | m_sda);
    always #12.5 ref_clk = ~ref_clk;
    two_wire_slave_tx #(.HOLD_CYC(4)) two_wire_slave_tx_inst (.ref_clk(ref_clk),
        .reset(reset), .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(wait_r),
        .scl_in(scl), .scl_out(), .scl_oe(scl_e), .sda_in(sda), .sda_out(), .sda_oe(sda_e),
        .arb_lost_in_addr(arb), .general_call_seen(), .start_sent(), .bus_owned());
    i2c_mst i2c_mst_inst (.scl(scl), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD value exp %h got %h", e, g);
        end
    endtask
    always @(posedge ref_clk) if (req.read && wait_r === 1'b0 && pend) cmp(exp_q.pop_front(), rdata);
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] dd, input logic c);
        int n = 0;
        if (c) exp_q.push_back({24'h0, dd});
        @(posedge ref_clk);
        pend <= c;
        req <= '{read: ~w, write: w, address: a, byteenable: 4'hF, writedata: {24'h0, dd}};
        do begin @(posedge ref_clk); n++; end while (wait_r !== 1'b0 && n < 50);
        v = rdata[7:0];
        req <= '0;
        if (n >= 50) begin mismatches++; print_verdict(); end
    endtask
    task automatic wflag();
        int n = 0;
        do begin acc(0, OFS_CTRL, 0, 0); n++; end while (v[B_DONE] !== 1'b1 && n < 200);
        if (n >= 200) begin mismatches++; print_verdict(); end
    endtask
    initial begin
        #2ms mismatches++;
        print_verdict();
    end
    initial begin
        void'($urandom(88));
        repeat (3) @(posedge ref_clk);
        reset <= 0;
        acc(0, OFS_CTRL, CTRL_RST, 1);
        acc(0, OFS_STAT, ST_NONE, 1);
        acc(0, OFS_DATA, DATA_RST, 1);
        acc(0, 4'h6, 8'h00, 1);
        acc(1, OFS_ADDR, 8'hA4, 0);
        acc(1, OFS_CTRL, 8'h44, 0);
        i2c_mst_inst.start();
        i2c_mst_inst.xfer(9'h14B, r);
        cmp(0, r[0]);
        wflag();
        acc(0, OFS_STAT, ST_SLA_R, 1);
        for (int k = 0; k < 2; k++) begin
            d = 8'($urandom);
            acc(1, OFS_DATA, d, 0);
            acc(1, OFS_CTRL, k ? 8'h84 : 8'hC4, 0);
            i2c_mst_inst.xfer({8'hFF, 1'(k)}, r);
            cmp({d, 1'(k)}, r);
            wflag();
            acc(0, OFS_STAT, k ? ST_DATA_NACK : ST_DATA_ACK, 1);
        end
        acc(1, OFS_CTRL, 8'h84, 0);
        i2c_mst_inst.xfer(9'h1FF, r);
        cmp(9'h1FF, r);
        i2c_mst_inst.start();
        i2c_mst_inst.xfer(9'h14B, r);
        cmp(1, r[0]);
        i2c_mst_inst.stop();
        $display("test tx done");
        acc(1, OFS_CTRL, 8'h44, 0);
        i2c_mst_inst.start();
        // the loss is reported after the START, before the first address bit is clocked
        @(posedge ref_clk);
        arb <= 1;
        @(posedge ref_clk);
        arb <= 0;
        i2c_mst_inst.xfer(9'h14B, r);
        wflag();
        acc(0, OFS_STAT, ST_ARB_SLA_R, 1);
        acc(1, OFS_CTRL, 8'h84, 0);
        i2c_mst_inst.xfer(9'h1FE, r);
        wflag();
        acc(0, OFS_STAT, ST_LAST_ACK, 1);
        acc(1, OFS_CTRL, 8'hC4, 0);
        i2c_mst_inst.stop();
        i2c_mst_inst.start();
        repeat (3) i2c_mst_inst.bit_x(1'b1, r[0]);
        i2c_mst_inst.stop();
        wflag();
        acc(0, OFS_STAT, ST_BUS_ERR, 1);
        acc(1, OFS_CTRL, 8'hD4, 0);
        acc(0, OFS_CTRL, 8'h44, 1);
        cmp(0, {scl_e, sda_e});
        acc(0, OFS_STAT, ST_NONE, 1);
        $display("test error done");
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- logic/tw_pkg.sv ----
`default_nettype none
package tw_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned START_HOLD_NS  = 4000;
    // least time: round up to whole cycles
    localparam int unsigned START_HOLD_CYC =
        (START_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // ------------------------------------------------------------
    // register map (byte addresses) and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h8;
    localparam logic [3:0] OFS_ADDR = 4'hC;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hFF;

    // serial_control_register fields
    localparam int unsigned B_DONE  = 7;
    localparam int unsigned B_ACKEN = 6;
    localparam int unsigned B_STA   = 5;
    localparam int unsigned B_STO   = 4;
    localparam int unsigned B_WCOL  = 3;
    localparam int unsigned B_EN    = 2;
    localparam int unsigned B_IRQEN = 0;
    // own_address_register: address in 7:1, general_call_enable in 0
    localparam int unsigned B_GCE   = 0;

    // ------------------------------------------------------------
    // status codes (full byte, prescale bits zero)
    // ------------------------------------------------------------
    localparam logic [7:0] ST_SLA_R     = 8'hA8;
    localparam logic [7:0] ST_ARB_SLA_R = 8'hB0;
    localparam logic [7:0] ST_DATA_ACK  = 8'hB8;
    localparam logic [7:0] ST_DATA_NACK = 8'hC0;
    localparam logic [7:0] ST_LAST_ACK  = 8'hC8;
    localparam logic [7:0] ST_NONE      = 8'hF8;
    localparam logic [7:0] ST_BUS_ERR   = 8'h00;
    localparam logic [3:0] BITS_LAST    = 4'h7;
    localparam logic [3:0] BITS_ADDR    = 4'h8;

    typedef enum logic [7:0] {
        S_IDLE     = 8'b0000_0001,
        S_ADDR     = 8'b0000_0010,
        S_ADDR_ACK = 8'b0000_0100,
        S_TX       = 8'b0000_1000,
        S_TX_ACK   = 8'b0001_0000,
        S_WAIT_TX  = 8'b0010_0000,
        S_WAIT_END = 8'b0100_0000,
        S_ERR      = 8'b1000_0000
    } slave_state_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } av_req_s;
endpackage
`default_nettype wire

// ---- logic/two_wire_slave_tx.sv ----
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_tx
    import tw_pkg::*;
#(
    parameter int unsigned HOLD_CYC = tw_pkg::START_HOLD_CYC
) (
    input  wire  logic            ref_clk,
    input  wire  logic            reset,
    input  wire  tw_pkg::av_req_s avs_req,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    input  wire  logic            scl_in,
    output logic                  scl_out,
    output logic                  scl_oe,
    input  wire  logic            sda_in,
    output logic                  sda_out,
    output logic                  sda_oe,
    input  wire  logic            arb_lost_in_addr,
    output logic                  general_call_seen,
    output logic                  start_sent,
    output logic                  bus_owned
);
    import tw_pkg::*;

    if (HOLD_CYC < 2 || HOLD_CYC > 65535) begin : g_chk
        $error("HOLD_CYC out of range");
    end

    // ------------------------------------------------------------
    // pin synchronisers and bus conditions
    // ------------------------------------------------------------
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
        end
    end
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise  = scl_s[1] & ~scl_s[2];
    assign scl_fall  = ~scl_s[1] & scl_s[2];
    assign start_det = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    assign stop_det  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

    // ------------------------------------------------------------
    // avalon slave: one wait state on every access
    // ------------------------------------------------------------
    logic       ack_r;
    logic       req;
    logic       wr_go;
    logic [7:0] wd;
    assign req             = avs_req.read | avs_req.write;
    assign avs_waitrequest = req & ~ack_r;
    assign wr_go           = avs_req.write & ack_r & avs_req.byteenable[0];
    assign wd              = avs_req.writedata[7:0];
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    logic ctrl_wr;
    logic data_wr;
    logic sw_clear;
    logic done_r;
    assign ctrl_wr  = wr_go && avs_req.address == OFS_CTRL;
    assign data_wr  = wr_go && avs_req.address == OFS_DATA;
    assign sw_clear = ctrl_wr && wd[B_DONE] && done_r;

    // ------------------------------------------------------------
    // control, address, prescale and data registers
    // ------------------------------------------------------------
    logic       ack_en_r;
    logic       sta_r;
    logic       sto_r;
    logic       en_r;
    logic       irqen_r;
    logic       wcol_r;
    logic [7:0] own_addr_r;
    logic [1:0] presc_r;
    logic [7:0] data_r;
    logic [4:0] code_r;
    logic [4:0] stat_code;
    slave_state_e st_r;
    logic       shift_now;
    assign shift_now = st_r == S_TX && scl_fall;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            {ack_en_r, sta_r, sto_r, en_r, irqen_r} <= 5'h00;
        end else if (ctrl_wr) begin
            ack_en_r <= wd[B_ACKEN];
            sta_r    <= wd[B_STA];
            en_r     <= wd[B_EN];
            irqen_r  <= wd[B_IRQEN];
            // in slave states the flag clear consumes stop_request
            sto_r    <= wd[B_STO] & ~(wd[B_DONE] & done_r);
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            own_addr_r <= ADDR_RST;
            presc_r    <= 2'h0;
        end else if (wr_go) begin
            if (avs_req.address == OFS_ADDR) own_addr_r <= wd;
            if (avs_req.address == OFS_STAT) presc_r <= wd[1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            data_r <= DATA_RST;
            wcol_r <= 1'b0;
        end else begin
            if (data_wr && done_r) begin
                data_r <= wd;
                wcol_r <= 1'b0;
            end else if (shift_now) begin
                data_r <= {data_r[6:0], 1'b1};
            end
            // collision set wins over the clearing write
            if (data_wr && !done_r) wcol_r <= 1'b1;
        end
    end

    assign stat_code = done_r ? code_r : ST_NONE[7:3];

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (req && !ack_r) begin
            unique case (avs_req.address)
                OFS_CTRL: avs_readdata <= {24'h00_0000, done_r, ack_en_r, sta_r,
                                           sto_r, wcol_r, en_r, 1'b0, irqen_r};
                OFS_STAT: avs_readdata <= {24'h00_0000, stat_code, 1'b0, presc_r};
                OFS_DATA: avs_readdata <= {24'h00_0000, data_r};
                OFS_ADDR: avs_readdata <= {24'h00_0000, own_addr_r};
                default:  avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // slave transmitter sequencing
    // ------------------------------------------------------------
    logic [3:0] cnt_r;
    logic [7:0] rx_r;
    logic       sda_low_r;
    logic       arb_r;
    logic       last_r;
    logic       ackd_r;
    logic       gc_r;
    logic       own_hit;
    logic       gc_hit;
    logic       in_frame;
    assign own_hit  = ack_en_r && rx_r[7:1] == own_addr_r[7:1];
    assign gc_hit   = ack_en_r && own_addr_r[B_GCE] && rx_r == 8'h00;
    assign in_frame = (st_r == S_ADDR && cnt_r != 4'h0) || st_r == S_ADDR_ACK ||
                      st_r == S_TX || st_r == S_TX_ACK;
    assign general_call_seen = gc_r;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r      <= S_IDLE;
            cnt_r     <= 4'h0;
            rx_r      <= 8'h00;
            sda_low_r <= 1'b0;
            arb_r     <= 1'b0;
            last_r    <= 1'b0;
            ackd_r    <= 1'b0;
            done_r    <= 1'b0;
            code_r    <= ST_NONE[7:3];
            gc_r      <= 1'b0;
        end else begin
            gc_r <= 1'b0;
            if (sw_clear) done_r <= 1'b0;
            if (!en_r) begin
                st_r      <= S_IDLE;
                sda_low_r <= 1'b0;
            end else if (in_frame && (start_det || stop_det)) begin
                st_r      <= S_ERR;
                sda_low_r <= 1'b0;
                code_r    <= ST_BUS_ERR[7:3];
                done_r    <= 1'b1;
            end else begin
                unique case (st_r)
                    S_IDLE: begin
                        // released: extra master clocks read ones
                        sda_low_r <= 1'b0;
                        arb_r     <= 1'b0;
                        cnt_r     <= 4'h0;
                        if (start_det) st_r <= S_ADDR;
                    end
                    S_ADDR: begin
                        if (arb_lost_in_addr) arb_r <= 1'b1;
                        if (stop_det) begin
                            st_r <= S_IDLE;
                        end else if (start_det) begin
                            cnt_r <= 4'h0;
                        end else if (scl_rise) begin
                            rx_r  <= {rx_r[6:0], sda_s[1]};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall && cnt_r == BITS_ADDR) begin
                            cnt_r <= 4'h0;
                            // write direction belongs to the receiver unit
                            gc_r  <= gc_hit;
                            if (own_hit && rx_r[0]) begin
                                st_r      <= S_ADDR_ACK;
                                sda_low_r <= 1'b1;
                            end else begin
                                st_r <= S_IDLE;
                            end
                        end
                    end
                    S_ADDR_ACK: begin
                        if (scl_fall) begin
                            sda_low_r <= 1'b0;
                            done_r    <= 1'b1;
                            code_r    <= arb_r ? ST_ARB_SLA_R[7:3]
                                               : ST_SLA_R[7:3];
                            st_r      <= S_WAIT_TX;
                        end
                    end
                    S_WAIT_TX: begin
                        if (sw_clear) begin
                            cnt_r <= 4'h0;
                            if (wd[B_STO]) begin
                                st_r <= S_IDLE;
                            end else begin
                                st_r      <= S_TX;
                                last_r    <= ~wd[B_ACKEN];
                                sda_low_r <= ~data_r[7];
                            end
                        end
                    end
                    S_TX: begin
                        if (scl_fall) begin
                            cnt_r <= cnt_r + 4'h1;
                            if (cnt_r == BITS_LAST) begin
                                sda_low_r <= 1'b0;
                                st_r      <= S_TX_ACK;
                            end else begin
                                sda_low_r <= ~data_r[6];
                            end
                        end
                    end
                    S_TX_ACK: begin
                        if (scl_rise) ackd_r <= ~sda_s[1];
                        if (scl_fall) begin
                            done_r <= 1'b1;
                            if (!ackd_r) begin
                                code_r <= ST_DATA_NACK[7:3];
                                st_r   <= S_WAIT_END;
                            end else if (last_r) begin
                                code_r <= ST_LAST_ACK[7:3];
                                st_r   <= S_WAIT_END;
                            end else begin
                                code_r <= ST_DATA_ACK[7:3];
                                st_r   <= S_WAIT_TX;
                            end
                        end
                    end
                    S_WAIT_END: begin
                        // ack_enable and start_request as written take effect here
                        if (sw_clear) st_r <= S_IDLE;
                    end
                    S_ERR: begin
                        // internal only: lines stay released, no STOP driven
                        sda_low_r <= 1'b0;
                        if (sw_clear && wd[B_STO]) st_r <= S_IDLE;
                    end
                    default: st_r <= S_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // pending START and bus ownership
    // ------------------------------------------------------------
    logic        busy_r;
    logic        gen_sda_r;
    logic        gen_scl_r;
    logic        owned_r;
    logic        sent_r;
    logic [15:0] gcnt_r;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            busy_r    <= 1'b0;
            gen_sda_r <= 1'b0;
            gen_scl_r <= 1'b0;
            owned_r   <= 1'b0;
            sent_r    <= 1'b0;
            gcnt_r    <= 16'h0000;
        end else begin
            sent_r <= 1'b0;
            if (start_det) busy_r <= 1'b1;
            else if (stop_det) busy_r <= 1'b0;
            if (!en_r) begin
                {gen_sda_r, gen_scl_r, owned_r} <= 3'h0;
            end else if (owned_r) begin
                // a repeated START does not give the bus away
                if (stop_det) owned_r <= 1'b0;
                if (!sta_r) {gen_sda_r, gen_scl_r} <= 2'h0;
            end else if (gen_sda_r) begin
                gcnt_r <= gcnt_r + 16'h0001;
                if (gcnt_r == 16'(HOLD_CYC - 1)) begin
                    gen_scl_r <= 1'b1;
                    owned_r   <= 1'b1;
                    sent_r    <= 1'b1;
                end
            end else if (sta_r && !busy_r && st_r == S_IDLE) begin
                gen_sda_r <= 1'b1;
                gcnt_r    <= 16'h0000;
            end
        end
    end

    logic stretch;
    assign stretch    = done_r && (st_r == S_WAIT_TX || st_r == S_WAIT_END);
    assign scl_out    = 1'b0;
    assign sda_out    = 1'b0;
    assign scl_oe     = stretch | gen_scl_r;
    assign sda_oe     = sda_low_r | gen_sda_r;
    assign start_sent = sent_r;
    assign bus_owned  = owned_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    AST_SLA_R: assert property ((st_r == S_ADDR_ACK && scl_fall && en_r && !in_frame_err()) ##0 !arb_r
        |=> done_r && code_r == ST_SLA_R[7:3] && st_r == S_WAIT_TX)
        else $error("own read address did not give A8");
    AST_ARB_SLA_R: assert property ((st_r == S_ADDR_ACK && scl_fall && en_r && !in_frame_err()
        && arb_r) |=> code_r == ST_ARB_SLA_R[7:3] && done_r)
        else $error("lost arbitration read address did not give B0");
    AST_DATA_ACK: assert property ((st_r == S_TX_ACK && scl_fall && en_r && !in_frame_err()
        && ackd_r && !last_r) |=> code_r == ST_DATA_ACK[7:3] && st_r == S_WAIT_TX)
        else $error("acked byte did not give B8");
    AST_DATA_NACK: assert property ((st_r == S_TX_ACK && scl_fall && en_r && !in_frame_err()
        && !ackd_r) |=> code_r == ST_DATA_NACK[7:3] && st_r == S_WAIT_END)
        else $error("nacked byte did not give C0");
    AST_LAST_ACK: assert property ((st_r == S_TX_ACK && scl_fall && en_r && !in_frame_err()
        && ackd_r && last_r) |=> code_r == ST_LAST_ACK[7:3] && done_r)
        else $error("acked last byte did not give C8");
    AST_NO_ACK_OFF: assert property ((st_r == S_ADDR && scl_fall && cnt_r == BITS_ADDR
        && !ack_en_r && en_r && !start_det && !stop_det) |=> st_r == S_IDLE && !sda_oe)
        else $error("address acked with ack_enable clear");
    AST_BUS_ERR: assert property ((en_r && start_det && (st_r == S_TX || st_r == S_TX_ACK))
        |=> st_r == S_ERR && done_r && code_r == ST_BUS_ERR[7:3])
        else $error("mid frame START not reported as bus error");
    AST_RECOVER: assert property ((st_r == S_ERR && en_r && sw_clear && wd[B_STO])
        |=> st_r == S_IDLE && !sto_r && !sda_low_r ##1 !sda_low_r)
        else $error("bus error recovery failed");
    AST_STRETCH: assert property ((done_r && st_r == S_WAIT_TX && !ctrl_wr && en_r)
        |=> scl_oe)
        else $error("SCL not stretched while flag set");
    AST_MSB_FIRST: assert property ((st_r == S_WAIT_TX && en_r && sw_clear && !wd[B_STO])
        |=> sda_oe == !$past(data_r[7]) && st_r == S_TX)
        else $error("first bit is not the MSB");
    AST_OWNED: assert property ((owned_r && en_r && start_det && !stop_det)
        |=> owned_r)
        else $error("ownership lost on repeated START");
    AST_START_REQ: assert property ((en_r && sta_r && !busy_r && st_r == S_IDLE && !owned_r
        && !gen_sda_r) |=> gen_sda_r)
        else $error("pending START not issued on free bus");
    AST_STATUS_NONE: assert property ((!done_r && avs_req.read && !ack_r
        && avs_req.address == OFS_STAT) |=> avs_readdata[7:3] == ST_NONE[7:3])
        else $error("status not F8 while flag clear");

    COV_READ_ADDR: cover property (st_r == S_ADDR_ACK ##[1:1000] code_r == ST_SLA_R[7:3]);
    COV_LAST_ACK: cover property (done_r && code_r == ST_LAST_ACK[7:3]);
    COV_RECOVER: cover property (st_r == S_ERR ##[1:1000] st_r == S_IDLE);

    function automatic logic in_frame_err();
        return start_det || stop_det;
    endfunction
endmodule
`default_nettype wire
